// ==== pkg/acf_pkg.sv ====
// Shared constants for the cascadable FIFO host controller
//
// Contract
// RULE1: Devices hold 512, 1024 or 2048 nine-bit words; separate pointers.
// RULE2: Apply one master clear cycle after power-up before any access.
// RULE3: Master clear empties the device; half and full flags go inactive.
// RULE4: Hold both strobes high before and after master clear rises.
// RULE5: A read right after master clear gives high-impedance outputs.
// RULE6: Falling write strobe starts a cycle; word stored at its rising edge.
// RULE7: Full flag high while room remains; low on last filling write.
// RULE8: Full flag falls during the write that fills the last location.
// RULE9: Writes to a full device are ignored, pointer held.
// RULE10: Empty flag rises after the first write strobe rising edge.
// RULE11: Half flag falls once occupancy reaches half plus one word.
// RULE12: Half flag rises after the read that brings occupancy to half.
// RULE13: A read cycle starts only while the empty flag is not low.
// RULE14: Outputs float while read high, empty, or inactive in a cascade.
// RULE15: With one word held, the falling read strobe drives empty low.
// RULE16: Reads of an empty device are ignored, pointer held.
// RULE17: Replay pulse rewinds the read pointer in standalone and width modes.
// RULE18: Strobes stay high during replay and recovery; writes within depth.
// RULE19: Flags may move during replay and are valid when it ends.
// RULE20: Standalone or width mode: cascade in low, first select high.
// RULE21: Depth mode is set at master clear; only first device selects low.
// RULE22: In depth mode the device pulses cascade out on last location access.
// RULE23: Depth mode: host combines flags; no half flag, no replay.
// RULE24: In depth mode the half flag pin carries the cascade output.
`default_nettype none
package acf_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int ACF_NDEV    = 2;   // Devices on the shared strobes
   localparam int ACF_WORD_W  = 9;
   localparam int ACF_SYNC    = 3;   // Stages on every pin input
   localparam int ACF_CNT_W   = 8;
   localparam int ACF_CLK_NS  = 10;  // ref_clk period

   // ****************************************************************
   // Pin timing, slowest speed grade so any grade works
   // ****************************************************************
   localparam int ACF_PULSE_NS  = 65;  // Least strobe and clear low time
   localparam int ACF_ACCESS_NS = 65;  // Read low to data valid
   localparam int ACF_PRE_NS    = 65;  // Strobes high before clear rises
   localparam int ACF_FLAG_NS   = 80;  // Worst flag settle after any edge
   localparam int ACF_PULSE_CYC =
      (ACF_PULSE_NS + ACF_CLK_NS - 1) / ACF_CLK_NS;
   localparam int ACF_ACCESS_CYC =
      (ACF_ACCESS_NS + ACF_CLK_NS - 1) / ACF_CLK_NS;
   localparam int ACF_PRE_CYC =
      (ACF_PRE_NS + ACF_CLK_NS - 1) / ACF_CLK_NS;
   localparam int ACF_FLAG_CYC =
      (ACF_FLAG_NS + ACF_CLK_NS - 1) / ACF_CLK_NS;
   localparam logic [ACF_CNT_W-1:0] ACF_LEN_PULSE = ACF_CNT_W'(ACF_PULSE_CYC);
   localparam logic [ACF_CNT_W-1:0] ACF_LEN_READ  =
      ACF_CNT_W'(ACF_ACCESS_CYC + ACF_SYNC);
   localparam logic [ACF_CNT_W-1:0] ACF_LEN_PRE   = ACF_CNT_W'(ACF_PRE_CYC);
   localparam logic [ACF_CNT_W-1:0] ACF_LEN_REC   =
      ACF_CNT_W'(ACF_FLAG_CYC + ACF_SYNC);
   localparam logic [ACF_CNT_W-1:0] ACF_LEN_NONE  = 8'h00;

   // ****************************************************************
   // Register map, byte addresses
   // ****************************************************************
   localparam logic [7:0] ACF_REG_CMD    = 8'h00;
   localparam logic [7:0] ACF_REG_WDATA  = 8'h04;
   localparam logic [7:0] ACF_REG_RDATA  = 8'h08;
   localparam logic [7:0] ACF_REG_STATUS = 8'h0C;
   localparam logic [7:0] ACF_REG_CONFIG = 8'h10;

   localparam int ACF_CMD_CLEAR  = 0;
   localparam int ACF_CMD_WRITE  = 1;
   localparam int ACF_CMD_READ   = 2;
   localparam int ACF_CMD_REPLAY = 3;

   localparam int ACF_ST_BUSY    = 0;
   localparam int ACF_ST_INIT    = 1;
   localparam int ACF_ST_EMPTY   = 2;
   localparam int ACF_ST_HALF    = 3;
   localparam int ACF_ST_FULL    = 4;
   localparam int ACF_ST_WR_REF  = 5;
   localparam int ACF_ST_RD_REF  = 6;
   localparam int ACF_ST_RT_REF  = 7;
   localparam int ACF_ST_DEPTH   = 8;

   localparam int ACF_CFG_DEPTH  = 0;

   typedef enum logic [2:0] {
      ACF_OP_IDLE, ACF_OP_CLEAR, ACF_OP_WRITE, ACF_OP_READ, ACF_OP_REPLAY
   } acf_op_t;

endpackage : acf_pkg
`default_nettype wire

// ==== pkg/acf_tmr_if.sv ====
// Handshake between the host sequencer and its strobe timer
`timescale 1ns/100ps
`default_nettype none
interface acf_tmr_if;
   import acf_pkg::*;
   logic                 start;     // One-cycle request
   logic [ACF_CNT_W-1:0] lead_len;  // High cycles before the low phase
   logic [ACF_CNT_W-1:0] low_len;   // Low phase cycles
   logic [ACF_CNT_W-1:0] rec_len;   // High recovery cycles after
   logic                 strobe_low;
   logic                 low_end;   // Last cycle of the low phase
   logic                 done;      // Last cycle of recovery

   modport ctl (output start, lead_len, low_len, rec_len,
                input  strobe_low, low_end, done);
   modport tmr (input  start, lead_len, low_len, rec_len,
                output strobe_low, low_end, done);
endinterface : acf_tmr_if
`default_nettype wire

// ==== rtl/acf_strobe_timer.sv ====
// Three-phase strobe timer: lead high, low pulse, recovery high
`timescale 1ns/100ps
`default_nettype none
module acf_strobe_timer
   import acf_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // Sequencer side
   acf_tmr_if.tmr    t
);

   typedef enum logic [1:0] {TM_IDLE, TM_LEAD, TM_LOW, TM_REC} acf_tm_t;

   acf_tm_t              phase_q;
   logic [ACF_CNT_W-1:0] cnt_q;

   // ****************************************************************
   // Phase sequencing
   // ****************************************************************
   // A zero lead skips straight to the low phase
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= TM_IDLE;
         cnt_q   <= '0;
      end else begin
         case (phase_q)
            TM_IDLE: begin
               if (t.start) begin
                  if (t.lead_len != ACF_LEN_NONE) begin
                     phase_q <= TM_LEAD;
                     cnt_q   <= t.lead_len - 1'b1;
                  end else begin
                     phase_q <= TM_LOW;
                     cnt_q   <= t.low_len - 1'b1;
                  end
               end
            end
            TM_LEAD: begin
               cnt_q <= cnt_q - 1'b1;
               if (cnt_q == '0) begin
                  phase_q <= TM_LOW;
                  cnt_q   <= t.low_len - 1'b1;
               end
            end
            TM_LOW: begin
               cnt_q <= cnt_q - 1'b1;
               if (cnt_q == '0) begin
                  phase_q <= TM_REC;
                  cnt_q   <= t.rec_len - 1'b1;
               end
            end
            TM_REC: begin
               cnt_q <= cnt_q - 1'b1;
               if (cnt_q == '0) begin
                  phase_q <= TM_IDLE;
               end
            end
            default: begin
               phase_q <= TM_IDLE;
            end
         endcase
      end
   end

   // Decodes of the phase flop, glitch free
   assign t.strobe_low = (phase_q == TM_LOW);
   assign t.low_end    = (phase_q == TM_LOW) && (cnt_q == '0);
   assign t.done       = (phase_q == TM_REC) && (cnt_q == '0);

endmodule : acf_strobe_timer
`default_nettype wire

// ==== rtl/acf_host.sv ====
// APB-controlled host that drives cascadable FIFO devices over their pins
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module acf_host
   import acf_pkg::*;
(
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output var  logic [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Device strobes, shared by all devices
   output logic                       master_clear_n,
   output logic                       write_n,
   output logic                       read_n,
   output logic                       replay_n,
   output var  logic [ACF_WORD_W-1:0] write_word,
   // Device configuration pins
   output logic [ACF_NDEV-1:0]        first_device_sel_n,
   output logic [ACF_NDEV-1:0]        cascade_in_n,
   output logic [ACF_NDEV-1:0]        cascade_in_oe,
   // Device outputs
   input  wire logic [ACF_WORD_W-1:0] read_word,
   input  wire logic [ACF_NDEV-1:0]   empty_flag_n,
   input  wire logic [ACF_NDEV-1:0]   half_level_flag_n,
   input  wire logic [ACF_NDEV-1:0]   no_room_flag_n
);

   localparam int PIN_W = ACF_WORD_W + 3 * ACF_NDEV;

   acf_tmr_if tif ();

   acf_op_t               op_q;
   logic                  start_q, init_q, depth_q, cfg_depth_q;
   logic                  wr_ref_q, rd_ref_q, rt_ref_q;
   logic [ACF_WORD_W-1:0] rdata_q, word_f;
   logic [PIN_W-1:0]      s1_q, s2_q, s3_q, filt_q, agree;
   logic [ACF_NDEV-1:0]   empty_f, half_f, full_f;
   logic                  is_empty, is_half, is_full;
   logic                  setup, access, hit, wr_cmd, wr_status;
   logic                  go_clear, go_replay, go_write, go_read;
   logic                  ref_wr, ref_rd, ref_rt;
   logic [31:0]           status;

   acf_strobe_timer u_timer (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .t       (tif.tmr)
   );

   // ****************************************************************
   // Pin input synchronisers
   // ****************************************************************
   // Three stages; a bit moves only once stages two and three agree,
   // which rejects a glitch that a bit holds for one sample only
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= {read_word, empty_flag_n, half_level_flag_n, no_room_flag_n};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign agree = ~(s2_q ^ s3_q);

   // Filtered copy; flags read active until the pins settle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         filt_q <= '0;
      end else begin
         filt_q <= (agree & s3_q) | (~agree & filt_q);
      end
   end

   assign {word_f, empty_f, half_f, full_f} = filt_q;

   // Composite flags: in depth mode only all-empty or all-full counts,
   // and the half pins carry cascade pulses so they are ignored
   assign is_empty = ~(|empty_f);                    // RULE23
   assign is_full  = ~(|full_f);                     // RULE23
   assign is_half  = ~depth_q & ~(|half_f);          // RULE23 RULE24

   // ****************************************************************
   // APB slave, zero wait states
   // ****************************************************************
   assign setup  = psel & ~penable;
   assign access = psel & penable;
   assign pready = 1'b1;

   always_comb begin
      case (paddr)
         ACF_REG_CMD, ACF_REG_WDATA, ACF_REG_RDATA,
         ACF_REG_STATUS, ACF_REG_CONFIG: hit = 1'b1;
         default:                        hit = 1'b0;
      endcase
   end

   assign pslverr   = access & ~hit;
   assign wr_cmd    = access & pwrite & (paddr == ACF_REG_CMD);
   assign wr_status = access & pwrite & (paddr == ACF_REG_STATUS);

   always_comb begin
      status                = '0;
      status[ACF_ST_BUSY]   = (op_q != ACF_OP_IDLE);
      status[ACF_ST_INIT]   = init_q;
      status[ACF_ST_EMPTY]  = is_empty;
      status[ACF_ST_HALF]   = is_half;
      status[ACF_ST_FULL]   = is_full;
      status[ACF_ST_WR_REF] = wr_ref_q;
      status[ACF_ST_RD_REF] = rd_ref_q;
      status[ACF_ST_RT_REF] = rt_ref_q;
      status[ACF_ST_DEPTH]  = depth_q;
   end

   // Read data captured in the setup cycle, held through access
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= '0;
      end else if (setup && !pwrite) begin
         case (paddr)
            ACF_REG_WDATA:  prdata <= 32'(write_word);
            ACF_REG_RDATA:  prdata <= 32'(rdata_q);
            ACF_REG_STATUS: prdata <= status;
            ACF_REG_CONFIG: prdata <= 32'(cfg_depth_q);
            default:        prdata <= '0;
         endcase
      end
   end

   // Write word and configuration; the word is held through the
   // whole strobe so data hold after the rising edge is met
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         write_word  <= '0;
         cfg_depth_q <= 1'b0;
      end else if (access && pwrite && op_q != ACF_OP_WRITE) begin
         if (paddr == ACF_REG_WDATA) begin
            write_word <= pwdata[ACF_WORD_W-1:0];
         end
         if (paddr == ACF_REG_CONFIG) begin
            cfg_depth_q <= pwdata[ACF_CFG_DEPTH];
         end
      end
   end

   // ****************************************************************
   // Command decode and refusal
   // ****************************************************************
   // Priority clear, replay, write, read; ignored while busy
   always_comb begin
      go_clear  = 1'b0;
      go_replay = 1'b0;
      go_write  = 1'b0;
      go_read   = 1'b0;
      ref_wr    = 1'b0;
      ref_rd    = 1'b0;
      ref_rt    = 1'b0;
      if (wr_cmd && op_q == ACF_OP_IDLE) begin
         if (pwdata[ACF_CMD_CLEAR]) begin
            go_clear = 1'b1;
         end else if (pwdata[ACF_CMD_REPLAY]) begin
            go_replay = init_q & ~depth_q;                  // RULE23
            ref_rt    = ~go_replay;
         end else if (pwdata[ACF_CMD_WRITE]) begin
            go_write = init_q & ~is_full;                   // RULE2 RULE9
            ref_wr   = ~go_write;
         end else if (pwdata[ACF_CMD_READ]) begin
            go_read = init_q & ~is_empty;                   // RULE13 RULE16
            ref_rd  = ~go_read;
         end
      end
   end

   // Sticky refusal flags, write one to clear; a new refusal wins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ref_q <= 1'b0;
         rd_ref_q <= 1'b0;
         rt_ref_q <= 1'b0;
      end else begin
         wr_ref_q <= ref_wr |
                     (wr_ref_q & ~(wr_status & pwdata[ACF_ST_WR_REF]));
         rd_ref_q <= ref_rd |
                     (rd_ref_q & ~(wr_status & pwdata[ACF_ST_RD_REF]));
         rt_ref_q <= ref_rt |
                     (rt_ref_q & ~(wr_status & pwdata[ACF_ST_RT_REF]));
      end
   end

   // ****************************************************************
   // Operation sequencer
   // ****************************************************************
   // Only one operation runs at a time, so no strobe is ever low while
   // clear or replay is active
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_q    <= ACF_OP_IDLE;
         start_q <= 1'b0;
      end else begin
         start_q <= go_clear | go_replay | go_write | go_read;
         case (op_q)
            ACF_OP_IDLE: begin
               if (go_clear) begin
                  op_q <= ACF_OP_CLEAR;
               end else if (go_replay) begin
                  op_q <= ACF_OP_REPLAY;
               end else if (go_write) begin
                  op_q <= ACF_OP_WRITE;
               end else if (go_read) begin
                  op_q <= ACF_OP_READ;
               end
            end
            ACF_OP_CLEAR, ACF_OP_WRITE, ACF_OP_READ, ACF_OP_REPLAY: begin
               if (tif.done) begin
                  op_q <= ACF_OP_IDLE;
               end
            end
            default: begin
               op_q <= ACF_OP_IDLE;
            end
         endcase
      end
   end

   assign tif.start = start_q;

   // Phase lengths; recovery also covers flag settling plus the
   // synchroniser so the next refusal check sees fresh flags
   always_comb begin
      tif.lead_len = ACF_LEN_NONE;
      tif.low_len  = ACF_LEN_PULSE;
      tif.rec_len  = ACF_LEN_REC;                  // RULE18 RULE19
      case (op_q)
         ACF_OP_CLEAR: tif.lead_len = ACF_LEN_PRE; // RULE4
         ACF_OP_READ:  tif.low_len  = ACF_LEN_READ;
         default:      tif.lead_len = ACF_LEN_NONE;
      endcase
   end

   // Initialised flag is set only by a finished clear; depth mode is loaded when a clear starts
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         init_q  <= 1'b0;
         depth_q <= 1'b0;
      end else if (go_clear) begin
         init_q  <= 1'b0;
         depth_q <= cfg_depth_q;                   // RULE21
      end else if (op_q == ACF_OP_CLEAR && tif.done) begin
         init_q  <= 1'b1;                          // RULE2
      end
   end

   // Read word taken on the last low cycle, after access plus sync
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else if (op_q == ACF_OP_READ && tif.low_end) begin
         rdata_q <= word_f;
      end
   end

   // ****************************************************************
   // Pin drive
   // ****************************************************************
   assign master_clear_n = ~(op_q == ACF_OP_CLEAR  && tif.strobe_low);
   assign write_n        = ~(op_q == ACF_OP_WRITE  && tif.strobe_low);
   assign read_n         = ~(op_q == ACF_OP_READ   && tif.strobe_low);
   assign replay_n       = ~(op_q == ACF_OP_REPLAY && tif.strobe_low);

   // Standalone ties cascade in low and selects high; depth mode
   // releases cascade in to the ring and marks device 0 as first
   assign cascade_in_n  = '0;                                   // RULE20
   assign cascade_in_oe = {ACF_NDEV{~cfg_depth_q}};             // RULE20
   assign first_device_sel_n =
      cfg_depth_q ? ~ACF_NDEV'(1) : '1;                         // RULE21

endmodule : acf_host
`default_nettype wire

// ==== verification/acf_dev_model.sv ====
// Behavioural model of two width-expanded FIFO devices on shared strobes
`timescale 1ns/100ps
`default_nettype none
module acf_dev_model
   import acf_pkg::*;
#(
   parameter int DEPTH = 512,
   parameter int DLY   = 20
)
(
   // Shared strobes and data in
   input  wire logic                  master_clear_n,
   input  wire logic                  write_n,
   input  wire logic                  read_n,
   input  wire logic                  replay_n,
   input  wire logic [ACF_WORD_W-1:0] write_word,
   // Device outputs, identical in width expansion
   output logic [ACF_WORD_W-1:0]      read_word,
   output logic [ACF_NDEV-1:0]        empty_flag_n,
   output logic [ACF_NDEV-1:0]        half_level_flag_n,
   output logic [ACF_NDEV-1:0]        no_room_flag_n
);
   // ********
   // Storage
   // ********
   logic [ACF_WORD_W-1:0] mem [DEPTH];
   logic [ACF_WORD_W-1:0] last_q = '0;
   logic                  wr_go  = 1'b0;
   logic                  rd_go  = 1'b0;
   int                    wa, wb, ra, rb;  // Begun and done counts
   // Clear empties the part; no cascade ring is modelled
   always @(negedge master_clear_n) begin
      wa = 0;
      wb = 0;
      ra = 0;
      rb = 0;
   end
   // Replay rewinds reads only; flags follow the pointers
   always @(negedge replay_n) begin
      ra = 0;
      rb = 0;
   end
   // Room is claimed on the falling edge so full drops early
   always @(negedge write_n) begin
      wr_go = (wa - rb < DEPTH);
      if (wr_go) wa++;
   end
   // Word is stored on the rising edge
   always @(posedge write_n) if (wr_go) begin
      mem[wb % DEPTH] = write_word;
      wb++;
   end
   // Read starts only when a stored word exists
   always @(negedge read_n) begin
      rd_go = (wb != ra);
      if (rd_go) ra++;
   end
   // Read ends on the rising edge, freeing the location
   always @(posedge read_n) if (rd_go) begin
      last_q = mem[rb % DEPTH];
      rb++;
      rd_go = 1'b0;
   end
   // Floating bus shows the inverse so a stale capture shows up
   assign #(DLY) read_word =
      (!read_n && rd_go) ? mem[rb % DEPTH] : ~last_q;
   assign #(DLY) empty_flag_n = {ACF_NDEV{wb != ra}};
   assign #(DLY) no_room_flag_n =
      {ACF_NDEV{wa - rb != DEPTH}};
   assign #(DLY) half_level_flag_n =
      {ACF_NDEV{wa - rb <= DEPTH / 2}};
endmodule : acf_dev_model
`default_nettype wire

// ==== verification/acf_host_properties.sv ====
// Checker for the pin sequencing of the FIFO host controller
`timescale 1ns/100ps
`default_nettype none
module acf_host_properties
   import acf_pkg::*;
(
   // Clock and reset
   input wire logic                  ref_clk,
   input wire logic                  rst_n,
   // Device pins
   input wire logic                  master_clear_n,
   input wire logic                  write_n,
   input wire logic                  read_n,
   input wire logic                  replay_n,
   input wire logic [ACF_WORD_W-1:0] write_word,
   input wire logic [ACF_NDEV-1:0]   first_device_sel_n,
   input wire logic [ACF_NDEV-1:0]   cascade_in_n,
   input wire logic [ACF_NDEV-1:0]   cascade_in_oe
);
   // ********
   // Checks
   // ********
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic cleared_q;
   // Remembers a clear pulse since reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) cleared_q <= 1'b0;
      else if (!master_clear_n) cleared_q <= 1'b1;
   end
   property p_clr_quiet; !master_clear_n |-> write_n && read_n; endproperty
   a_clr_quiet: assert property (p_clr_quiet)
      else $error("strobe low in clear");
   property p_clr_post;
      $rose(master_clear_n) |-> (write_n && read_n)[*2];
   endproperty
   a_clr_post: assert property (p_clr_post)
      else $error("strobe low after clear");
   property p_rt_quiet; !replay_n |-> write_n && read_n; endproperty
   a_rt_quiet: assert property (p_rt_quiet)
      else $error("strobe low in replay");
   property p_rt_post; $rose(replay_n) |-> (write_n && read_n)[*2];
   endproperty
   a_rt_post: assert property (p_rt_post)
      else $error("strobe low after replay");
   property p_init; !write_n || !read_n |-> cleared_q; endproperty
   a_init: assert property (p_init)
      else $error("access before clear");
   property p_wr_len; $fell(write_n) |-> (!write_n)[*7] ##1 write_n;
   endproperty
   a_wr_len: assert property (p_wr_len)
      else $error("write pulse length");
   property p_wr_hold; !$past(write_n) |-> $stable(write_word); endproperty
   a_wr_hold: assert property (p_wr_hold)
      else $error("write data moved");
   property p_cfg;
      cascade_in_n == 2'b00 && first_device_sel_n ==
      (cascade_in_oe == 2'b11 ? 2'b11 : 2'b10);
   endproperty
   a_cfg: assert property (p_cfg)
      else $error("configuration pins");
   property p_depth_rt; cascade_in_oe == 2'b00 |-> replay_n; endproperty
   a_depth_rt: assert property (p_depth_rt)
      else $error("replay in depth mode");
endmodule : acf_host_properties
bind acf_host acf_host_properties u_props (.*);
`default_nettype wire

// ==== verification/tb_async_cascadable_fifo.sv ====
// Self-checking bench for the FIFO host controller
`timescale 1ns/100ps
`default_nettype none
module tb_async_cascadable_fifo;
   import acf_pkg::*;
   // ********
   // Signals
   // ********
   typedef struct {logic wr; logic [7:0] a; logic [31:0] d, e;} acf_row_t;
   logic        ref_clk = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata, rd_q;
   logic        pready, pslverr, err_q;
   logic        master_clear_n, write_n, read_n, replay_n;
   logic [8:0]  write_word;
   logic [1:0]  first_device_sel_n, cascade_in_n, cascade_in_oe;
   wire  [8:0]  read_word;
   wire  [1:0]  empty_flag_n, half_level_flag_n, no_room_flag_n;
   int          num_errors = 0;
   int          tests_run  = 0;
   int          i;
   acf_row_t    rows [4] = '{
      '{1'b1, ACF_REG_WDATA, 32'hFFFF_FFFF, 32'h0000_0000},
      '{1'b0, ACF_REG_WDATA, 32'h0000_0000, 32'h0000_01FF},
      '{1'b0, ACF_REG_CONFIG, 32'h0000_0000, 32'h0000_0000},
      '{1'b0, 8'h14, 32'h0000_0000, 32'h0000_0000}};
   always #5 ref_clk = ~ref_clk;
   acf_host DUT (.*);
   acf_dev_model u_dev (.*);
   // Verdict and end of run
   task automatic conclude();
      if (num_errors == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // One APB transfer and an idle cycle, so the next never overlaps
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n = 0;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
      rd_q  = prdata;
      err_q = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
      if (n >= 50) begin num_errors++; conclude(); end
   endtask : apb
   task automatic st(input logic [31:0] m, e);
      apb(1'b0, ACF_REG_STATUS, 32'h0000_0000);
      chk("status", e, rd_q & m);
   endtask : st
   // Command, then poll busy under a bound
   task automatic op(input int b);
      int n = 0;
      apb(1'b1, ACF_REG_CMD, 32'h0000_0001 << b);
      do apb(1'b0, ACF_REG_STATUS, 32'h0000_0000);
      while (rd_q[ACF_ST_BUSY] !== 1'b0 && ++n < 100);
      if (n >= 100) begin num_errors++; conclude(); end
   endtask : op
   task automatic rd(input int k);
      op(ACF_CMD_READ);
      apb(1'b0, ACF_REG_RDATA, 32'h0000_0000);
      chk("data", 32'(k * 7 % 512), rd_q);
   endtask : rd
   // Main sequence
   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      chk("sel", 32'h0000_0003, first_device_sel_n);
      chk("cfg", 32'h0000_000C, {cascade_in_oe, cascade_in_n});
      foreach (rows[r]) begin
         apb(rows[r].wr, rows[r].a, rows[r].d);
         if (!rows[r].wr) chk("reg", rows[r].e, rd_q);
         chk("slverr", 32'(rows[r].a > 8'h10), 32'(err_q));
      end
      op(ACF_CMD_WRITE);
      st(32'h0000_0022, 32'h0000_0020);
      apb(1'b1, ACF_REG_STATUS, 32'h0000_00E0);
      op(ACF_CMD_CLEAR);
      st(32'h0000_003E, 32'h0000_0006);
      op(ACF_CMD_READ);
      st(32'h0000_0040, 32'h0000_0040);
      for (i = 0; i < 512; i++) begin
         apb(1'b1, ACF_REG_WDATA, 32'(i * 7 % 512));
         op(ACF_CMD_WRITE);
         if (i == 0) st(32'h0000_0004, 32'h0000_0000);
         if (i == 255) st(32'h0000_0008, 32'h0000_0000);
         if (i == 256) st(32'h0000_0008, 32'h0000_0008);
         if (i == 510) st(32'h0000_0010, 32'h0000_0000);
      end
      st(32'h0000_0010, 32'h0000_0010);
      op(ACF_CMD_WRITE);
      st(32'h0000_0020, 32'h0000_0020);
      for (i = 0; i < 255; i++) rd(i);
      st(32'h0000_0008, 32'h0000_0008);
      rd(255);
      st(32'h0000_0008, 32'h0000_0000);
      op(ACF_CMD_REPLAY);
      st(32'h0000_0014, 32'h0000_0010);
      for (i = 0; i < 512; i++) rd(i);
      st(32'h0000_0004, 32'h0000_0004);
      apb(1'b1, ACF_REG_STATUS, 32'h0000_00E0);
      op(ACF_CMD_READ);
      st(32'h0000_0040, 32'h0000_0040);
      apb(1'b1, ACF_REG_CONFIG, 32'h0000_0001);
      op(ACF_CMD_CLEAR);
      st(32'h0000_010C, 32'h0000_0104);
      chk("sel", 32'h0000_0002, first_device_sel_n);
      op(ACF_CMD_REPLAY);
      st(32'h0000_0080, 32'h0000_0080);
      // Reset in the middle of a write pulse
      apb(1'b1, ACF_REG_CMD, 32'h0000_0002);
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b0;
      @(posedge ref_clk);
      chk("strobe", 32'h0000_0001, write_n);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      st(32'h0000_0002, 32'h0000_0000);
      conclude();
   end
endmodule : tb_async_cascadable_fifo
`default_nettype wire
